/* File: rtl/bsw_bcd_digit.sv */
/*
 * One BCD digit counting 0 to MAX with a synchronous clear.
 * Assumes step and clear are single-cycle levels sampled on clk.
 */
`timescale 1ns/100ps
module bsw_bcd_digit #(
    parameter logic [3:0] MAX = bsw_pkg::DIGIT_MAX
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       clear,
    input  wire logic       step,
    output logic [3:0]      value,
    output logic            wrap
);

    if (MAX < 4'h1) begin : g_bad_max
        $error("bsw_bcd_digit: MAX must be at least 1");
    end

    logic [3:0] value_r;
    logic [3:0] value_nxt;

    always_comb begin
        value_nxt = value_r;
        if (clear) begin
            value_nxt = bsw_pkg::RST_DIGIT;
        end else if (step) begin
            value_nxt = (value_r >= MAX) ? 4'h0 : value_r + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            value_r <= bsw_pkg::RST_DIGIT;
        end else begin
            value_r <= value_nxt;
        end
    end

    assign value = value_r;
    assign wrap  = step && !clear && (value_r == MAX);

    digit_bound_a: assert property (@(posedge clk) disable iff (!reset_n)
        value_r <= MAX)
        else $error("BCD digit out of range");

endmodule

/* File: rtl/bsw_pkg.sv */
/*
 * Shared constants and types of the two-digit BCD stopwatch timer:
 * register offsets, bit positions, reset values, step pattern, bus carrier.
 * Assumes a 4-bit register port with an 8-bit address space.
 */
package bsw_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 4;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_HUNDREDTHS = 8'hE2;
    localparam logic [ADDR_W-1:0] OFS_TENTHS     = 8'hE3;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'hEA;
    localparam logic [ADDR_W-1:0] OFS_FLAGS      = 8'hEE;
    localparam logic [ADDR_W-1:0] OFS_CONTROL    = 8'hF9;

    // Field positions
    localparam int BIT_TENTH_TICK  = 0;
    localparam int BIT_SECOND_TICK = 1;
    localparam int BIT_SW_CLEAR    = 0;
    localparam int BIT_SW_RUN      = 1;
    localparam int BIT_CT_CLEAR    = 2;

    // Reset values
    localparam logic [3:0] RST_DIGIT  = 4'h0;
    localparam logic [1:0] RST_ENABLE = 2'h0;
    localparam logic [1:0] RST_FLAGS  = 2'h0;
    localparam logic       RST_RUN    = 1'b0;

    // Step pattern in 256 Hz ticks
    localparam logic [1:0] STEP_SHORT     = 2'h2;
    localparam logic [1:0] STEP_LONG      = 2'h3;
    localparam logic [3:0] DIGIT_MAX      = 4'h9;
    localparam logic [3:0] LONG_SLOT      = 4'h8;
    // Tenths values whose hundredths cycle lasts 26 ticks, else 25
    localparam logic [9:0] LONG_TENTHS    = 10'h35A;
    localparam int         TICKS_PER_SEC  = 256;

    typedef enum logic [1:0] {
        ST_STOPPED = 2'b01,
        ST_RUNNING = 2'b10
    } bsw_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bsw_bus_req_s;

    typedef struct packed {
        logic [3:0] tenths;
        logic [3:0] hundredths;
    } bsw_count_s;

    // Ticks for the step that leaves hundredths value h under tenths t
    function automatic logic [1:0] bsw_step_len(input logic [3:0] h,
                                                input logic [3:0] t);
        logic long_cycle;
        long_cycle = (t <= DIGIT_MAX) ? LONG_TENTHS[t] : 1'b0;
        if (h[0] || (long_cycle && h == LONG_SLOT)) begin
            return STEP_LONG;
        end
        return STEP_SHORT;
    endfunction

endpackage

/* File: rtl/bsw_stopwatch.sv */
/*
 * Two-digit BCD stopwatch timer with overflow flags, masks and interrupt.
 * Assumes TICK_256 is a one-cycle pulse at 256 Hz synchronous to CLK, and
 * a register master that never issues read and write together.
 */
// Implementation choice: the strobed register port.
// Functional notes
// (R1) Two cascaded BCD digits 0..9; hundredths from 256 Hz ticks, tenths from its carry.
// (R2) Hundredths advance after alternately 2 or 3 ticks, a cycle of 25 or 26 ticks.
// (R3) Per tenths cycle four 25-tick and six 26-tick cycles, so the 1 Hz carry is exact.
// (R4) A 9-to-0 wrap of each digit sets its overflow flag and raises its event.
// (R5) Flags are set on wrap whatever the mask; the mask only gates the request.
// (R6) Mask bit 0 enables the 10 Hz interrupt and bit 1 the 1 Hz one, readable and writable.
// (R7) Reading the flag register clears both flags; writes to it are ignored.
// (R8) Both digits read as 4-bit BCD values and writes to them do nothing.
// (R9) Writing 1 to the clear bit zeroes both digits; running goes on from zero, stopped holds.
// (R10) Writing 0 to the clear bit does nothing and the bit always reads 0.
// (R11) The run bit counts when 1 and freezes the digits when 0, resuming from the held value.
// (R12) Initial reset zeroes digits, masks, flags and run bit.
// (R13) Software stops the timer to read both digits and restarts within 976 us.
// (R14) Software takes care reading flags with interrupts enabled, a set may race the read.
// (R15) The interrupt output is high while any flag and its mask bit are both 1.
`timescale 1ns/100ps
module bsw_stopwatch (
    input  wire logic                      CLK,
    input  wire logic                      RESET_N,
    input  wire logic                      TICK_256,
    input  wire bsw_pkg::bsw_bus_req_s     BUS_REQ,
    output logic [bsw_pkg::DATA_W-1:0]     BUS_RDATA,
    output logic                           IRQ
);

    // Bus decode
    logic wr_hund;
    logic wr_tenth;
    logic wr_enable;
    logic wr_flags;
    logic wr_ctrl;
    logic rd_flags;

    assign wr_hund   = BUS_REQ.wr && BUS_REQ.addr == bsw_pkg::OFS_HUNDREDTHS;
    assign wr_tenth  = BUS_REQ.wr && BUS_REQ.addr == bsw_pkg::OFS_TENTHS;
    assign wr_enable = BUS_REQ.wr && BUS_REQ.addr == bsw_pkg::OFS_IRQ_ENABLE;
    assign wr_flags  = BUS_REQ.wr && BUS_REQ.addr == bsw_pkg::OFS_FLAGS;
    assign wr_ctrl   = BUS_REQ.wr && BUS_REQ.addr == bsw_pkg::OFS_CONTROL;
    assign rd_flags  = BUS_REQ.rd && BUS_REQ.addr == bsw_pkg::OFS_FLAGS;

    // Run state
    bsw_pkg::bsw_state_e state_r;
    bsw_pkg::bsw_state_e state_nxt;
    logic                run;
    logic                sw_clear;

    assign sw_clear = wr_ctrl && BUS_REQ.wdata[bsw_pkg::BIT_SW_CLEAR]; // see (R9) (R10)

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            bsw_pkg::ST_STOPPED: begin
                if (wr_ctrl && BUS_REQ.wdata[bsw_pkg::BIT_SW_RUN]) begin
                    state_nxt = bsw_pkg::ST_RUNNING; // see (R11)
                end
            end
            bsw_pkg::ST_RUNNING: begin
                if (wr_ctrl && !BUS_REQ.wdata[bsw_pkg::BIT_SW_RUN]) begin
                    state_nxt = bsw_pkg::ST_STOPPED; // see (R11)
                end
            end
            default: begin
                state_nxt = bsw_pkg::ST_STOPPED;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r <= bsw_pkg::ST_STOPPED; // see (R12)
        end else begin
            state_r <= state_nxt;
        end
    end

    assign run = (state_r == bsw_pkg::ST_RUNNING);

    // Tick divider for the hundredths digit
    logic [1:0] sub_r;
    logic [1:0] sub_nxt;
    logic [1:0] step_len;
    logic       hund_step;
    logic [3:0] hund;
    logic [3:0] tenth;
    logic       hund_wrap;
    logic       tenth_wrap;

    assign step_len  = bsw_pkg::bsw_step_len(hund, tenth); // see (R2) (R3)
    assign hund_step = run && TICK_256 && (sub_r == step_len - 2'h1);

    always_comb begin
        sub_nxt = sub_r;
        if (sw_clear) begin
            sub_nxt = 2'h0; // see (R9)
        end else if (run && TICK_256) begin
            sub_nxt = hund_step ? 2'h0 : sub_r + 2'h1; // see (R2) (R11)
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sub_r <= 2'h0;
        end else begin
            sub_r <= sub_nxt;
        end
    end

    // Cascaded digits
    bsw_bcd_digit #(
        .MAX     (bsw_pkg::DIGIT_MAX)
    ) u_hundredths (
        .clk     (CLK),
        .reset_n (RESET_N),
        .clear   (sw_clear),
        .step    (hund_step),
        .value   (hund),
        .wrap    (hund_wrap)
    ); // see (R1) (R12)

    bsw_bcd_digit #(
        .MAX     (bsw_pkg::DIGIT_MAX)
    ) u_tenths (
        .clk     (CLK),
        .reset_n (RESET_N),
        .clear   (sw_clear),
        .step    (hund_wrap),
        .value   (tenth),
        .wrap    (tenth_wrap)
    ); // see (R1)

    // Interrupt mask
    logic [1:0] enable_r;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            enable_r <= bsw_pkg::RST_ENABLE; // see (R12)
        end else if (wr_enable) begin
            enable_r <= BUS_REQ.wdata[1:0]; // see (R6)
        end
    end

    // Overflow flags, a wrap in the clearing cycle wins
    logic [1:0] flags_r;
    logic [1:0] flags_set;

    assign flags_set = {tenth_wrap, hund_wrap}; // see (R4) (R5)

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            flags_r <= bsw_pkg::RST_FLAGS; // see (R12)
        end else begin
            flags_r <= (rd_flags ? 2'h0 : flags_r) | flags_set; // see (R7)
        end
    end

    assign IRQ = |(flags_r & enable_r); // see (R15)

    // Read data, one cycle after the strobe
    logic [3:0] rdata_nxt;

    always_comb begin
        rdata_nxt = 4'h0;
        if (BUS_REQ.rd) begin
            case (BUS_REQ.addr)
                bsw_pkg::OFS_HUNDREDTHS: rdata_nxt = hund;  // see (R8)
                bsw_pkg::OFS_TENTHS:     rdata_nxt = tenth; // see (R8)
                bsw_pkg::OFS_IRQ_ENABLE: rdata_nxt = {2'h0, enable_r};
                bsw_pkg::OFS_FLAGS:      rdata_nxt = {2'h0, flags_r};
                bsw_pkg::OFS_CONTROL:    rdata_nxt = {2'h0, run, 1'b0}; // see (R10)
                default:                 rdata_nxt = 4'h0;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            BUS_RDATA <= 4'h0;
        end else begin
            BUS_RDATA <= rdata_nxt;
        end
    end

    // Checking helpers
    logic [1:0] chk_ticks_r;
    logic [8:0] chk_sec_r;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            chk_ticks_r <= 2'h0;
        end else if (sw_clear || hund_step) begin
            chk_ticks_r <= 2'h0;
        end else if (run && TICK_256 && chk_ticks_r != 2'h3) begin
            chk_ticks_r <= chk_ticks_r + 2'h1;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            chk_sec_r <= 9'h000;
        end else if (sw_clear || tenth_wrap) begin
            chk_sec_r <= 9'h000;
        end else if (run && TICK_256 && chk_sec_r != 9'h1FF) begin
            chk_sec_r <= chk_sec_r + 9'h001;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    digits_bcd_a: assert property ( // see (R1)
        hund <= bsw_pkg::DIGIT_MAX && tenth <= bsw_pkg::DIGIT_MAX)
        else $error("stopwatch digit not BCD");

    step_ticks_a: assert property ( // see (R2)
        hund_step |-> (chk_ticks_r == 2'h1 || chk_ticks_r == 2'h2))
        else $error("hundredths step not after 2 or 3 ticks");

    second_exact_a: assert property ( // see (R3)
        tenth_wrap |-> chk_sec_r == 9'h0FF)
        else $error("tenths carry not after 256 ticks");

    wrap_sets_flag_a: assert property ( // see (R4)
        hund_wrap |=> flags_r[0] && hund == 4'h0)
        else $error("hundredths wrap did not set flag");

    masked_flag_a: assert property ( // see (R5)
        tenth_wrap && !enable_r[1] && !wr_enable
        |=> flags_r[1] && (IRQ == (flags_r[0] && enable_r[0])))
        else $error("masked wrap mishandled");

    flag_write_a: assert property ( // see (R7)
        wr_flags && flags_set == 2'h0 |=> flags_r == $past(flags_r))
        else $error("flag write changed the flags");

    mask_readback_a: assert property ( // see (R6)
        wr_enable ##1 (BUS_REQ.rd && BUS_REQ.addr == bsw_pkg::OFS_IRQ_ENABLE
            && !wr_enable)
        |=> BUS_RDATA == {2'h0, $past(BUS_REQ.wdata[1:0], 2)})
        else $error("mask bits did not read back");

    read_clears_a: assert property ( // see (R7)
        rd_flags && flags_set == 2'h0 |=> flags_r == 2'h0
            && BUS_RDATA == {2'h0, $past(flags_r)})
        else $error("flag read did not clear flags");

    digit_write_a: assert property ( // see (R8)
        (wr_hund || wr_tenth) && !run |=> $stable(hund) && $stable(tenth))
        else $error("digit write changed the count");

    clear_zero_a: assert property ( // see (R9)
        sw_clear |=> hund == 4'h0 && tenth == 4'h0 && sub_r == 2'h0)
        else $error("clear did not zero the digits");

    ctrl_read_a: assert property ( // see (R10)
        BUS_REQ.rd && BUS_REQ.addr == bsw_pkg::OFS_CONTROL
        |=> BUS_RDATA[bsw_pkg::BIT_SW_CLEAR] == 1'b0
            && BUS_RDATA[bsw_pkg::BIT_SW_RUN] == $past(run))
        else $error("control read wrong");

    stopped_hold_a: assert property ( // see (R11)
        !run && !sw_clear |=> $stable(hund) && $stable(tenth)
            && $stable(sub_r))
        else $error("count moved while stopped");

    irq_follow_a: assert property ( // see (R15)
        hund_wrap && enable_r[0] && !wr_enable |=> IRQ)
        else $error("enabled wrap raised no interrupt");

    hund_wrap_c: cover property (hund_wrap);
    second_wrap_c: cover property (tenth_wrap ##1 IRQ);
    clear_run_c: cover property (sw_clear && run);
    race_read_c: cover property (rd_flags && flags_set != 2'h0);
    stopped_tick_c: cover property (!run && TICK_256);

endmodule

/* File: testbench/tb_bsw_stopwatch.sv */
/*
 * Self-checking bench of the two-digit BCD stopwatch timer: register
 * access, tick counting, overflow flags, masks and interrupt.
 * Assumes bsw_pkg is compiled first and a 10 MHz clock.
 */
`timescale 1ns/100ps
module tb_bsw_stopwatch;
    logic                  CLK;
    logic                  RESET_N;
    logic                  TICK_256;
    bsw_pkg::bsw_bus_req_s req;
    logic [3:0]            rdata;
    logic                  irq;
    int                    bad_count;
    int                    n_compared;
    logic [31:0]           seed;
    logic [3:0]            m_h;
    logic [3:0]            m_t;
    logic [1:0]            m_p;
    logic [1:0]            m_flg;
    logic [1:0]            m_msk;
    logic                  m_run;

    bsw_stopwatch bsw_stopwatch_i (
        .CLK       (CLK),
        .RESET_N   (RESET_N),
        .TICK_256  (TICK_256),
        .BUS_REQ   (req),
        .BUS_RDATA (rdata),
        .IRQ       (irq)
    );

    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Ticks needed to leave hundredths value h under tenths value t
    function automatic logic [1:0] step_len(input logic [3:0] h,
                                            input logic [3:0] t);
        logic lng;
        lng = (t == 4'h1) || (t == 4'h3) || (t == 4'h4) || (t == 4'h6)
              || (t == 4'h8) || (t == 4'h9);
        return (h[0] || (lng && h == 4'h8)) ? 2'h3 : 2'h2;
    endfunction

    task automatic chk(input string name, input logic [3:0] exp,
                       input logic [3:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] d);
        @(posedge CLK);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge CLK);
        req.wr <= 1'b0;
        if (a == bsw_pkg::OFS_CONTROL) begin
            if (d[0]) begin
                m_h = 4'h0;
                m_t = 4'h0;
                m_p = 2'h0;
            end
            m_run = d[1];
        end
        if (a == bsw_pkg::OFS_IRQ_ENABLE) begin
            m_msk = d[1:0];
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [3:0] exp,
                      input string name);
        @(posedge CLK);
        req <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
        @(posedge CLK);
        req.rd <= 1'b0;
        @(negedge CLK);
        chk(name, exp, rdata);
        if (a == bsw_pkg::OFS_FLAGS) begin
            m_flg = 2'h0;
        end
    endtask

    task automatic chk_irq();
        @(negedge CLK);
        chk("irq", {3'h0, |(m_flg & m_msk)}, {3'h0, irq});
    endtask

    task automatic tick();
        @(posedge CLK);
        TICK_256 <= 1'b1;
        @(posedge CLK);
        TICK_256 <= 1'b0;
        if (m_run) begin
            m_p++;
            if (m_p == step_len(m_h, m_t)) begin
                m_p = 2'h0;
                m_h++;
                if (m_h == 4'hA) begin
                    m_h = 4'h0;
                    m_flg[0] = 1'b1;
                    m_t++;
                    if (m_t == 4'hA) begin
                        m_t = 4'h0;
                        m_flg[1] = 1'b1;
                    end
                end
            end
        end
    endtask

    task automatic check_all(input string name);
        chk_irq();
        rd(bsw_pkg::OFS_HUNDREDTHS, m_h, "hundredths");
        rd(bsw_pkg::OFS_TENTHS, m_t, "tenths");
        rd(bsw_pkg::OFS_IRQ_ENABLE, {2'h0, m_msk}, "mask");
        rd(bsw_pkg::OFS_CONTROL, {2'h0, m_run, 1'b0}, "control");
        rd(bsw_pkg::OFS_FLAGS, {2'h0, m_flg}, "flags");
        chk_irq();
        $display("test %s done", name);
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge CLK);
        bad_count++;
        $display("[ERR] watchdog expected done seen hang");
        end_of_test();
    end

    initial begin
        TICK_256 = 1'b0;
        req = '0;
        RESET_N = 1'b0;
        bad_count = 0;
        n_compared = 0;
        seed = 32'h00015F34;
        {m_h, m_t, m_p, m_flg, m_msk, m_run} = '0;
        repeat (16) @(posedge CLK);
        RESET_N <= 1'b1;
        check_all("reset");
        rd(8'h00, 4'h0, "unmapped");
        wr(bsw_pkg::OFS_HUNDREDTHS, 4'h5);
        wr(bsw_pkg::OFS_TENTHS, 4'h7);
        wr(bsw_pkg::OFS_FLAGS, 4'h3);
        wr(bsw_pkg::OFS_CONTROL, 4'h4);
        check_all("ignored writes");
        wr(bsw_pkg::OFS_CONTROL, 4'h3);
        tick();
        tick();
        check_all("first step");
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            wr(bsw_pkg::OFS_IRQ_ENABLE, {2'h0, seed[3:2]});
            wr(bsw_pkg::OFS_CONTROL,
               {2'h0, seed[4] | seed[5], seed[7:5] == 3'h0});
            repeat (seed[13:8]) begin
                tick();
                repeat (seed[15:14]) @(posedge CLK);
            end
            check_all("random round");
        end
        wr(bsw_pkg::OFS_CONTROL, 4'h3);
        rd(bsw_pkg::OFS_FLAGS, {2'h0, m_flg}, "flags");
        repeat (255) tick();
        check_all("one tick short");
        tick();
        wr(bsw_pkg::OFS_IRQ_ENABLE, 4'h0);
        chk_irq();
        wr(bsw_pkg::OFS_IRQ_ENABLE, 4'h2);
        chk_irq();
        check_all("full second");
        repeat (3) tick();
        wr(bsw_pkg::OFS_CONTROL, 4'h0);
        repeat (5) tick();
        check_all("frozen");
        wr(bsw_pkg::OFS_CONTROL, 4'h1);
        repeat (4) tick();
        check_all("cleared while stopped");
        wr(bsw_pkg::OFS_CONTROL, 4'h2);
        repeat (7) tick();
        check_all("resumed");
        end_of_test();
    end
endmodule
